// ===== verilog/sps_pkg.sv
// sps_pkg: constants, encodings and carrier structs of the stack program
// sequencer; assumes one 100 MHz clock domain and no bus.
package sps_pkg;
  // ------------------------------------------------------------------
  // data and stack
  // ------------------------------------------------------------------
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned STACK_DEPTH = 4;
  localparam int unsigned NUM_TBUF    = 4;
  localparam int unsigned NUM_AIO     = 3;
  localparam int unsigned NUM_DO      = 4;
  typedef logic [DATA_W-1:0] sps_word_t;

  // ------------------------------------------------------------------
  // program area and constant bank
  // ------------------------------------------------------------------
  localparam int unsigned IDX_W       = 6;
  localparam logic [5:0] STEP_FIRST   = 6'h01;
  localparam logic [5:0] STEP_LAST    = 6'h3B;
  localparam logic [5:0] STEP_FIRST_R = 6'h14;
  localparam logic [5:0] STEP_LAST_R  = 6'h3B;
  localparam logic [5:0] CONST_FIRST  = 6'h01;
  localparam logic [5:0] CONST_LAST   = 6'h3B;
  localparam logic [5:0] CONST_FIRST_R = 6'h14;
  localparam logic [5:0] CONST_LAST_R = 6'h3F;
  localparam int unsigned MEM_DEPTH   = 64;

  // ------------------------------------------------------------------
  // interval timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_MHZ     = 100;
  localparam int unsigned IVL50_MS    = 50;
  localparam int unsigned IVL100_MS   = 100;
  localparam int unsigned IVL200_MS   = 200;
  localparam int unsigned IVL50_CYC   = IVL50_MS * 1000 * CLK_MHZ;
  localparam int unsigned IVL100_CYC  = IVL100_MS * 1000 * CLK_MHZ;
  localparam int unsigned IVL200_CYC  = IVL200_MS * 1000 * CLK_MHZ;
  localparam logic [1:0] IVL_SEL_50   = 2'h0;
  localparam logic [1:0] IVL_SEL_100  = 2'h1;
  localparam logic [1:0] IVL_SEL_200  = 2'h2;

  // ------------------------------------------------------------------
  // dynamic instances
  // ------------------------------------------------------------------
  localparam int unsigned NUM_DYN     = 8;
  localparam logic [2:0] DYN_LAG1     = 3'h0;
  localparam logic [2:0] DYN_LAG2     = 3'h1;
  localparam logic [2:0] DYN_LAG3     = 3'h2;
  localparam logic [2:0] DYN_TIMER    = 3'h3;

  // ------------------------------------------------------------------
  // instruction word: opcode, operand class, index
  // ------------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NOP, OP_END, OP_PUSH, OP_COPY, OP_SWAP, OP_ROT, OP_JMP, OP_JIF,
    OP_ADD, OP_SUB, OP_MLT, OP_DIV, OP_SQR, OP_ABS, OP_HSL, OP_LSL,
    OP_HLM, OP_LLM, OP_FX, OP_CMP, OP_SW, OP_DYN
  } sps_op_e;

  typedef enum logic [2:0] {
    SRC_CONST, SRC_TBUF, SRC_AIN, SRC_AOUT, SRC_DIN, SRC_DOUT
  } sps_src_e;

  typedef struct packed {
    sps_op_e           op;
    sps_src_e          src;
    logic [IDX_W-1:0]  idx;
  } sps_instr_s;

  localparam int unsigned INSTR_W = $bits(sps_instr_s);

  typedef struct packed {
    logic              we;
    logic [IDX_W-1:0]  addr;
    sps_word_t         data;
  } sps_wr_s;

  typedef struct packed {
    logic              busy;
    logic              done;
    logic [IDX_W-1:0]  step;
    logic              dyn_refused;
  } sps_status_s;
endpackage

// ===== verilog/sps_mem.sv
// sps_mem: single write, single registered read memory.
// assumes caller holds address stable for one cycle of read latency.
`timescale 1ns/1ps
`default_nettype none
module sps_mem
  import sps_pkg::*;
#(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 64
)(
  // clock
  input  wire logic                      clk_sys,
  // write port
  input  wire logic                      wr_en,
  input  wire logic [$clog2(DEPTH)-1:0]  wr_addr,
  input  wire logic [WIDTH-1:0]          wr_data,
  // read port
  input  wire logic [$clog2(DEPTH)-1:0]  rd_addr,
  output logic      [WIDTH-1:0]          rd_data
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  always_ff @(posedge clk_sys)
  begin
    if (wr_en)
    begin
      mem_q[wr_addr] <= wr_data;
    end
    rd_data <= mem_q[rd_addr];
  end
endmodule // sps_mem
`default_nettype wire

// ===== verilog/sps_alu.sv
// sps_alu: one- and two-operand basic operations on stack top pair.
// assumes integer stand-in for the float unit; algorithm detail omitted.
`timescale 1ns/1ps
`default_nettype none
module sps_alu
  import sps_pkg::*;
(
  // operation
  input  wire sps_op_e   op,
  input  wire sps_word_t a_top,
  input  wire sps_word_t b_next,
  input  wire logic      fixed_pt,
  // result
  output sps_word_t      result,
  output logic           two_operand
);
  always_comb
  begin
    result      = a_top;
    two_operand = 1'b1;
    case (op)
      OP_ADD: result = b_next + a_top;
      OP_SUB: result = b_next - a_top;
      OP_MLT: result = fixed_pt ? b_next * a_top : b_next * a_top;
      OP_DIV: result = (a_top == '0) ? '0 : b_next / a_top;
      OP_HSL: result = ($signed(a_top) > $signed(b_next)) ? a_top : b_next;
      OP_LSL: result = ($signed(a_top) < $signed(b_next)) ? a_top : b_next;
      OP_HLM: result = ($signed(b_next) > $signed(a_top)) ? a_top : b_next;
      OP_LLM: result = ($signed(b_next) < $signed(a_top)) ? a_top : b_next;
      OP_CMP: result = {{(DATA_W-1){1'b0}},
                        ($signed(b_next) >= $signed(a_top))};
      OP_SW:  result = b_next;
      OP_ABS:
      begin
        result      = a_top[DATA_W-1] ? (~a_top + 1'b1) : a_top;
        two_operand = 1'b0;
      end
      OP_SQR:
      begin
        result      = a_top >> 1;
        two_operand = 1'b0;
      end
      default:
      begin
        result      = a_top;
        two_operand = 1'b0;
      end
    endcase
  end
endmodule // sps_alu
`default_nettype wire

// ===== verilog/sps_seq.sv
// sps_seq: stack program sequencer with stack, buffers and constant bank.
// assumes program and constant writes come from the terminal port.
// Behaviour
// RULE1: run starts at first program step, ends after last step executes.
// RULE2: end command stops the run at that step.
// RULE3: reduced variant uses program steps 20 to 59.
// RULE4: basic commands unlimited; each dynamic command once per interval.
// RULE5: dynamic commands keep state between intervals.
// RULE6: four retained buffers hold values, cleared only at power-up.
// RULE7: 59 settable constants; load pushes chosen constant.
// RULE8: both constant prefixes map onto the same storage.
// RULE9: reduced variant constant bank indexes 20 to 63.
// RULE10: time measurement is fixed point, others floating point.
// RULE11: unconditional and conditional jumps continue at named step.
// RULE12: stack swap, stack rotate, no-op and end commands exist.
// RULE13: unported analog regs serve as buffers, unported outputs as flags.
// RULE14: indexed dynamic instances each keep own state, once per interval.
// RULE15: line segment commands use a reserved constant region.
// RULE16: basic ops: arithmetic, root, abs, select, limit, fx, cmp, switch.
// RULE17: push shifts stack down dropping bottom; copy leaves stack.
// RULE18: two-operand result on top, rest move up, bottom kept.
// RULE19: each interval: input conversion, program run, output conversion.
// RULE20: jump outside program area ends the run.
`timescale 1ns/1ps
`default_nettype none
module sps_seq
  import sps_pkg::*;
(
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  // configuration
  input  wire logic             reduced_variant,
  input  wire logic [1:0]       interval_sel,
  // terminal writes
  input  wire sps_wr_s          prog_wr,
  input  wire sps_wr_s          const_wr,
  // converters
  input  wire sps_word_t        analog_in_reg [NUM_AIO],
  input  wire logic [2:0]       digital_in,
  output logic                  in_conv_req,
  output logic                  out_conv_req,
  output sps_word_t             analog_out_reg [NUM_AIO],
  output logic [NUM_DO-1:0]     digital_out_flag,
  // status
  output sps_word_t             retained_buffer_reg [NUM_TBUF],
  output sps_word_t             stack_reg [STACK_DEPTH],
  output sps_status_s           status
);
  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_INCONV, ST_FETCH, ST_WAIT, ST_EXEC, ST_OUTCONV
  } sps_state_e;

  sps_state_e            state_q, state_d;
  logic [IDX_W-1:0]      pc_q, pc_d;
  logic [31:0]           tick_q, tick_d;
  sps_word_t             stk_q [STACK_DEPTH];
  sps_word_t             stk_d [STACK_DEPTH];
  sps_word_t             tb_q [NUM_TBUF];
  sps_word_t             tb_d [NUM_TBUF];
  sps_word_t             ain_q [NUM_AIO];
  sps_word_t             ain_d [NUM_AIO];
  sps_word_t             aout_q [NUM_AIO];
  sps_word_t             aout_d [NUM_AIO];
  logic [NUM_DO-1:0]     dout_q, dout_d;
  logic [NUM_DYN-1:0]    dyn_used_q, dyn_used_d;
  sps_word_t             dyn_st_q [NUM_DYN];
  sps_word_t             dyn_st_d [NUM_DYN];
  logic                  refused_q, refused_d;
  logic                  done_q, done_d;
  logic [2:0]            din_s1_q, din_s2_q;

  // ------------------------------------------------------------------
  // memories and alu
  // ------------------------------------------------------------------
  logic [INSTR_W-1:0]    instr_raw;
  sps_instr_s            instr;
  sps_word_t             const_rd;
  sps_word_t             alu_res;
  logic                  alu_two;
  logic [IDX_W-1:0]      const_addr;
  logic [IDX_W-1:0]      first_step;
  logic [IDX_W-1:0]      last_step;
  logic [31:0]           ivl_cycles;

  assign instr = sps_instr_s'(instr_raw);
  assign first_step = reduced_variant ? STEP_FIRST_R : STEP_FIRST; // [RULE3]
  assign last_step  = reduced_variant ? STEP_LAST_R  : STEP_LAST;  // [RULE3]
  // either prefix gives the same index into one bank
  assign const_addr = instr_raw[IDX_W-1:0]; // [RULE8]

  sps_mem #(.WIDTH(INSTR_W), .DEPTH(MEM_DEPTH)) u_prog (
    .clk_sys (clk_sys),
    .wr_en   (prog_wr.we),
    .wr_addr (prog_wr.addr),
    .wr_data (prog_wr.data[INSTR_W-1:0]),
    .rd_addr (pc_q),
    .rd_data (instr_raw)
  );

  sps_mem #(.WIDTH(DATA_W), .DEPTH(MEM_DEPTH)) u_const (
    .clk_sys (clk_sys),
    .wr_en   (const_wr.we),
    .wr_addr (const_wr.addr),
    .wr_data (const_wr.data),
    .rd_addr (const_addr),
    .rd_data (const_rd)
  ); // [RULE7] [RULE9] [RULE15]

  sps_alu u_alu (
    .op          (instr.op),
    .a_top       (stk_q[0]),
    .b_next      (stk_q[1]),
    .fixed_pt    (1'b0),
    .result      (alu_res),
    .two_operand (alu_two)
  ); // [RULE16] [RULE10]

  always_comb
  begin
    case (interval_sel)
      IVL_SEL_50:  ivl_cycles = IVL50_CYC;
      IVL_SEL_200: ivl_cycles = IVL200_CYC;
      default:     ivl_cycles = IVL100_CYC;
    endcase
  end

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  logic      const_ok;
  sps_word_t operand;
  logic      run_end;
  always_comb
  begin
    state_d    = state_q;
    pc_d       = pc_q;
    tick_d     = (tick_q >= ivl_cycles - 32'h1) ? 32'h0 : tick_q + 32'h1;
    stk_d      = stk_q;
    tb_d       = tb_q;
    ain_d      = ain_q;
    aout_d     = aout_q;
    dout_d     = dout_q;
    dyn_used_d = dyn_used_q;
    dyn_st_d   = dyn_st_q;
    refused_d  = refused_q;
    done_d     = 1'b0;
    run_end    = 1'b0;
    const_ok   = reduced_variant
               ? (instr.idx >= CONST_FIRST_R && instr.idx <= CONST_LAST_R)
               : (instr.idx >= CONST_FIRST && instr.idx <= CONST_LAST);
    operand    = '0;
    case (instr.src)
      SRC_CONST: operand = const_ok ? const_rd : '0; // [RULE7] [RULE9]
      SRC_TBUF:  operand = tb_q[instr.idx[1:0]];
      SRC_AIN:   operand = ain_q[instr.idx[1:0] % 2'(NUM_AIO)];
      SRC_AOUT:  operand = aout_q[instr.idx[1:0] % 2'(NUM_AIO)];
      SRC_DIN:   operand = {{(DATA_W-1){1'b0}}, din_s2_q[instr.idx[1:0] % 2'h3]};
      SRC_DOUT:  operand = {{(DATA_W-1){1'b0}}, dout_q[instr.idx[1:0]]};
      default:   operand = '0;
    endcase
    case (state_q)
      ST_IDLE:
      begin
        if (tick_q == 32'h0)
        begin
          state_d    = ST_INCONV; // [RULE19]
          dyn_used_d = '0;        // [RULE4]
          refused_d  = 1'b0;
        end
      end
      ST_INCONV:
      begin
        ain_d   = analog_in_reg;
        pc_d    = first_step; // [RULE1]
        state_d = ST_FETCH;
      end
      ST_FETCH: state_d = ST_WAIT;
      ST_WAIT:  state_d = ST_EXEC;
      ST_EXEC:
      begin
        pc_d    = pc_q + 6'h01;
        state_d = ST_FETCH;
        case (instr.op)
          OP_NOP: ; // [RULE12]
          OP_END: run_end = 1'b1; // [RULE2] [RULE12]
          OP_PUSH:
          begin
            stk_d[3] = stk_q[2];
            stk_d[2] = stk_q[1];
            stk_d[1] = stk_q[0];
            stk_d[0] = operand; // [RULE17]
          end
          OP_COPY:
          begin
            case (instr.src)
              SRC_TBUF: tb_d[instr.idx[1:0]] = stk_q[0]; // [RULE6]
              SRC_AIN:  ain_d[instr.idx[1:0] % 2'(NUM_AIO)] = stk_q[0];
              SRC_AOUT: aout_d[instr.idx[1:0] % 2'(NUM_AIO)] = stk_q[0];
              SRC_DOUT: dout_d[instr.idx[1:0]] = stk_q[0][0]; // [RULE13]
              default: ;
            endcase
          end
          OP_SWAP:
          begin
            stk_d[0] = stk_q[1];
            stk_d[1] = stk_q[0]; // [RULE12]
          end
          OP_ROT:
          begin
            stk_d[0] = stk_q[1];
            stk_d[1] = stk_q[2];
            stk_d[2] = stk_q[3];
            stk_d[3] = stk_q[0]; // [RULE12]
          end
          OP_JMP, OP_JIF:
          begin
            if (instr.op == OP_JMP || stk_q[0] != '0)
            begin
              if (instr.idx < first_step || instr.idx > last_step)
              begin
                run_end = 1'b1; // [RULE20]
              end
              else
              begin
                pc_d = instr.idx; // [RULE11]
              end
            end
          end
          OP_DYN:
          begin
            if (dyn_used_q[instr.idx[2:0]])
            begin
              refused_d = 1'b1; // [RULE4] [RULE14]
            end
            else
            begin
              dyn_used_d[instr.idx[2:0]] = 1'b1;
              // fixed point elapsed time against held state
              dyn_st_d[instr.idx[2:0]] = (instr.idx[2:0] == DYN_TIMER)
                ? dyn_st_q[instr.idx[2:0]] + 32'h1
                : stk_q[0]; // [RULE5] [RULE10]
              stk_d[0] = dyn_st_q[instr.idx[2:0]];
            end
          end
          default:
          begin
            stk_d[0] = alu_res; // [RULE16]
            if (alu_two)
            begin
              stk_d[1] = stk_q[2];
              stk_d[2] = stk_q[3]; // [RULE18]
            end
          end
        endcase
        if (pc_q >= last_step)
        begin
          run_end = 1'b1; // [RULE1]
        end
        if (run_end)
        begin
          state_d = ST_OUTCONV;
        end
      end
      ST_OUTCONV:
      begin
        done_d  = 1'b1; // [RULE19]
        state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    din_s1_q <= digital_in;
    din_s2_q <= din_s1_q;
    if (!rst_b)
    begin
      state_q    <= ST_IDLE;
      pc_q       <= STEP_FIRST;
      tick_q     <= 32'h0;
      stk_q      <= '{default: '0};
      tb_q       <= '{default: '0}; // [RULE6]
      ain_q      <= '{default: '0};
      aout_q     <= '{default: '0};
      dout_q     <= '0;
      dyn_used_q <= '0;
      dyn_st_q   <= '{default: '0};
      refused_q  <= 1'b0;
      done_q     <= 1'b0;
    end
    else
    begin
      state_q    <= state_d;
      pc_q       <= pc_d;
      tick_q     <= tick_d;
      stk_q      <= stk_d;
      tb_q       <= tb_d;
      ain_q      <= ain_d;
      aout_q     <= aout_d;
      dout_q     <= dout_d;
      dyn_used_q <= dyn_used_d;
      dyn_st_q   <= dyn_st_d;
      refused_q  <= refused_d;
      done_q     <= done_d;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign in_conv_req         = (state_q == ST_INCONV);
  assign out_conv_req        = (state_q == ST_OUTCONV);
  assign analog_out_reg      = aout_q;
  assign digital_out_flag    = dout_q;
  assign retained_buffer_reg = tb_q;
  assign stack_reg           = stk_q;
  assign status.busy         = (state_q != ST_IDLE);
  assign status.done         = done_q;
  assign status.step         = pc_q;
  assign status.dyn_refused  = refused_q;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  sequence s_exec_end;
    state_q == ST_EXEC && instr.op == OP_END;
  endsequence
  a_end_stops_run: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_exec_end |=> state_q == ST_OUTCONV ##1 done_q) // [RULE2]
    else $error("end command did not stop run");
  a_start_first_step: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state_q == ST_INCONV |=> pc_q == first_step) // [RULE1] [RULE3]
    else $error("run not started at first step");
  a_push_shift: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state_q == ST_EXEC && instr.op == OP_PUSH
    |=> stk_q[1] == $past(stk_q[0]) && stk_q[3] == $past(stk_q[2])) // [RULE17]
    else $error("push did not shift stack");
  a_two_op_bottom: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state_q == ST_EXEC && instr.op == OP_ADD
    |=> stk_q[3] == $past(stk_q[3]) && stk_q[2] == $past(stk_q[3])) // [RULE18]
    else $error("two operand pop wrong");
  a_dyn_once: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state_q == ST_EXEC && instr.op == OP_DYN && dyn_used_q[instr.idx[2:0]]
    |=> refused_q && $stable(dyn_st_q[0]) && $stable(dyn_st_q[1])
    && $stable(dyn_st_q[2]) && $stable(dyn_st_q[3])) // [RULE4] [RULE14]
    else $error("dynamic command ran twice");
  a_tbuf_retained: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state_q == ST_INCONV |=> $stable(tb_q[0]) && $stable(tb_q[3])) // [RULE6]
    else $error("buffer cleared at interval start");
  a_jump_outside: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state_q == ST_EXEC && instr.op == OP_JMP && instr.idx > last_step
    |=> state_q == ST_OUTCONV) // [RULE20]
    else $error("out of area jump kept running");
  a_jump_target: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state_q == ST_EXEC && instr.op == OP_JMP && pc_q < last_step
    && instr.idx >= first_step && instr.idx <= last_step
    |=> pc_q == $past(instr.idx) ##2 state_q == ST_EXEC) // [RULE11]
    else $error("jump target not taken");
  a_last_step_ends: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state_q == ST_EXEC && pc_q == last_step |=> state_q == ST_OUTCONV) // [RULE1]
    else $error("run passed last step");
endmodule // sps_seq
`default_nettype wire

// ===== verif/sps_conv_model.sv
// sps_conv_model: input converter stand-in for the sequencer.
// assumes one clock; a fresh sample follows every capture strobe.
`timescale 1ns/1ps
`default_nettype none
module sps_conv_model
  import sps_pkg::*;
(
  // clock
  input  wire logic  clk_sys,
  // conversion strobe
  input  wire logic  in_conv_req,
  // converted inputs
  output sps_word_t  analog_in_reg [NUM_AIO],
  output logic [2:0] digital_in
);
  logic [7:0] smp_q = 8'h00;

  // new sample once per interval, never a stale repeat
  always @(posedge clk_sys)
    if (in_conv_req)
      smp_q <= smp_q + 8'h01;

  always_comb
  begin
    for (int i = 0; i < NUM_AIO; i++)
      analog_in_reg[i] = {24'h000000, smp_q} + i;
    digital_in = smp_q[2:0];
  end
endmodule // sps_conv_model
`default_nettype wire

// ===== verif/stack_program_sequencer_tb.sv
// stack_program_sequencer_tb: program runs, each after a power-up reset.
// assumes the sps_seq contract: done pulse ends every run.
`timescale 1ns/1ps
`default_nettype none
module stack_program_sequencer_tb;
  import sps_pkg::*;
  typedef struct {sps_word_t s[4]; logic ck; logic rf; sps_word_t y;
                  logic [3:0] d;} sps_exp_s;
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  logic        reduced_variant = 1'b0;
  logic [1:0]  interval_sel = 2'h0;
  sps_wr_s     prog_wr = '0;
  sps_wr_s     const_wr = '0;
  sps_word_t   analog_in_reg [NUM_AIO];
  sps_word_t   analog_out_reg [NUM_AIO];
  sps_word_t   retained_buffer_reg [NUM_TBUF];
  sps_word_t   stack_reg [STACK_DEPTH];
  logic [2:0]  digital_in;
  logic        in_conv_req;
  logic        out_conv_req;
  logic [NUM_DO-1:0] digital_out_flag;
  sps_status_s status;
  sps_word_t   cst [64];
  logic [19:0] pg [$];
  sps_exp_s    q [$];
  sps_exp_s    e;
  logic        out_q = 1'b0;
  int          num_errors = 0;
  int          checks_done = 0;

  always #5 clk_sys = ~clk_sys;

  sps_seq dut (.clk_sys(clk_sys), .rst_b(rst_b),
    .reduced_variant(reduced_variant), .interval_sel(interval_sel),
    .prog_wr(prog_wr), .const_wr(const_wr),
    .analog_in_reg(analog_in_reg), .digital_in(digital_in),
    .in_conv_req(in_conv_req), .out_conv_req(out_conv_req),
    .analog_out_reg(analog_out_reg),
    .digital_out_flag(digital_out_flag),
    .retained_buffer_reg(retained_buffer_reg),
    .stack_reg(stack_reg), .status(status));

  sps_conv_model conv (.clk_sys(clk_sys), .in_conv_req(in_conv_req),
    .analog_in_reg(analog_in_reg), .digital_in(digital_in));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  function automatic logic [19:0] st(logic [5:0] a, sps_op_e o,
                                     logic [5:0] i);
    return {a, o, SRC_CONST, i};
  endfunction

  // load program under reset, release, wait for the done pulse
  task automatic run(input logic rv, input sps_exp_s x);
    int n;
    @(negedge clk_sys);
    rst_b = 1'b0;
    reduced_variant = rv;
    interval_sel = 2'($urandom_range(3));
    for (int a = 0; a < 64; a++)
    begin
      prog_wr = '{1'b1, 6'(a), 32'h0};
      @(negedge clk_sys);
    end
    foreach (pg[k])
    begin
      prog_wr = '{1'b1, pg[k][19:14], {18'h0, pg[k][13:0]}};
      @(negedge clk_sys);
    end
    prog_wr.we = 1'b0;
    pg.delete();
    q.push_back(x);
    rst_b = 1'b1;
    n = 0;
    while (status.done !== 1'b1 && n < 1000)
    begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 1000)
      chk(32'h0, 32'h1);
    @(negedge clk_sys);
  endtask

  // scoreboard: oldest note against each finished run
  always @(negedge clk_sys)
  begin
    if (status.done === 1'b1)
    begin
      chk(out_q, 32'h1);
      if (q.size() == 0)
        chk(32'h0, 32'h1);
      else
      begin
        e = q.pop_front();
        chk(status.dyn_refused, e.rf);
        for (int i = 0; i < 4; i++)
        begin
          if (e.ck)
            chk(stack_reg[i], e.s[i]);
          chk(retained_buffer_reg[i], 32'h0);
        end
        chk(analog_out_reg[1], e.y);
        chk(32'(digital_out_flag), 32'(e.d));
      end
    end
    out_q = out_conv_req;
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    wrap_up();
  end

  initial
  begin
    void'($urandom(44030));
    repeat (5) @(negedge clk_sys);
    for (int a = 0; a < 64; a++)
    begin
      cst[a] = $urandom() | 32'h1;
      const_wr = '{1'b1, 6'(a), cst[a]};
      @(negedge clk_sys);
    end
    const_wr.we = 1'b0;
    // no line segment command used, whole bank free
    // five pushes drop the bottom, swap, copy, end stops
    for (int k = 1; k <= 5; k++)
      pg.push_back(st(6'(k), OP_PUSH, 6'(k)));
    pg.push_back(st(6'h06, OP_SWAP, 6'h00));
    pg.push_back({6'h07, OP_COPY, SRC_AOUT, 6'h01});
    pg.push_back({6'h08, OP_COPY, SRC_DOUT, 6'h02});
    pg.push_back(st(6'h09, OP_END, 6'h00));
    pg.push_back(st(6'h0A, OP_PUSH, 6'h06));
    run(1'b0, '{'{cst[4], cst[5], cst[3], cst[2]}, 1'b1, 1'b0,
                cst[4], 4'h4});
    // add keeps bottom, jump skips, last step executes
    for (int k = 1; k <= 4; k++)
      pg.push_back(st(6'(k), OP_PUSH, 6'(9 + k)));
    pg.push_back(st(6'h05, OP_ADD, 6'h00));
    pg.push_back(st(6'h06, OP_JMP, 6'h3A));
    pg.push_back(st(6'h07, OP_PUSH, 6'h1E));
    pg.push_back(st(6'h3A, OP_PUSH, 6'h14));
    pg.push_back(st(6'h3B, OP_PUSH, 6'h15));
    run(1'b0, '{'{cst[21], cst[20], cst[12] + cst[13], cst[11]},
                1'b1, 1'b0, 32'h0, 4'h0});
    // out-of-range constant, taken branch, jump out of area
    pg = '{st(6'h01, OP_PUSH, 6'h3C), st(6'h02, OP_PUSH, 6'h07),
           st(6'h03, OP_JIF, 6'h05), st(6'h04, OP_PUSH, 6'h08),
           st(6'h05, OP_JMP, 6'h3C), st(6'h06, OP_PUSH, 6'h09)};
    run(1'b0, '{'{cst[7], 32'h0, 32'h0, 32'h0}, 1'b1, 1'b0,
                32'h0, 4'h0});
    // each of dynamic instances 0 to 3 used twice is refused
    for (int d = 0; d < 4; d++)
    begin
      pg = '{st(6'h01, OP_PUSH, 6'h01), st(6'h02, OP_DYN, 6'(d)),
             st(6'h03, OP_DYN, 6'(d))};
      run(1'b0, '{'{32'h0, 32'h0, 32'h0, 32'h0}, 1'b0, 1'b1,
                  32'h0, 4'h0});
    end
    for (int d = 0; d < 4; d++)
      pg.push_back(st(6'(d + 1), OP_DYN, 6'(d)));
    run(1'b0, '{'{32'h0, 32'h0, 32'h0, 32'h0}, 1'b0, 1'b0,
                32'h0, 4'h0});
    // reduced variant: area and constant bank both move
    pg = '{st(6'h01, OP_PUSH, 6'h05), st(6'h14, OP_PUSH, 6'h3F),
           st(6'h15, OP_PUSH, 6'h14), st(6'h16, OP_PUSH, 6'h01),
           st(6'h17, OP_JMP, 6'h05), st(6'h05, OP_PUSH, 6'h06)};
    run(1'b1, '{'{32'h0, cst[20], cst[63], 32'h0}, 1'b1,
                1'b0, 32'h0, 4'h0});
    chk(32'(q.size()), 32'h0);
    wrap_up();
  end
endmodule // stack_program_sequencer_tb
`default_nettype wire
